// ===== prfc_command.sv
// How it works
// - rights granted only on bit 10 rise
// - bus loss never reported in image
// - reset requested by bit 7 rise
// - internal reset stretched to three seconds
// - start on rising edge of bit 0
// - mode byte taken only with bit 8
// - pump 1 frequency needs bit 5
// - pump 2 frequency needs bit 6
// - implausible frequencies are never applied
// - linked variant copies pump 1 controls
// - purge overrides valves after stop-request switch-off
// - mode 7 selects remote command
// - remote command runs pumps from bytes 4/14
// - mode codes 0, 1, 2 for A, B, C
`timescale 1ns/1ns
module prfc_command #(
  parameter int         HOLD_CYC  = prfc_pkg::RESET_HOLD_CYC,
  parameter int         PURGE_CYC = prfc_pkg::RESET_HOLD_CYC,
  parameter logic       LINKED    = 1'b0,
  parameter logic [7:0] MAX_F1    = prfc_pkg::MAX_F_ROOTS,
  parameter logic [7:0] MAX_F2    = prfc_pkg::MAX_F_SCREW
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        tel_valid_i,
  input  wire logic [8*prfc_pkg::IMG_BYTES-1:0] ctrl_img_i,
  input  wire logic                        purge_done_i,
  input  wire prfc_pkg::prfc_pump_state_t  upper_i,
  input  wire prfc_pkg::prfc_pump_state_t  lower_i,
  input  wire logic                        sys_ready_i,
  input  wire logic                        sys_error_i,
  input  wire logic                        sys_warning_i,
  input  wire logic [7:0]                  encl_temp_i,
  output logic [8*prfc_pkg::IMG_BYTES-1:0] stat_img_o,
  output logic                             remote_rights_o,
  output logic                             sys_reset_o,
  output logic                             sys_run_o,
  output logic [7:0]                       mode_o,
  output prfc_pkg::prfc_pump_cmd_t         pump1_o,
  output prfc_pkg::prfc_pump_cmd_t         pump2_o,
  output logic [prfc_pkg::VALVE_COUNT-1:0] valves_o,
  output logic                             purging_o,
  output logic                             freq_reject_o
);
  logic [15:0] ctl_word;
  logic [15:0] prev_ctl_ff;
  logic [7:0]  b_valve, b_p1, b_p2, b_f1, b_f2, b_mode;
  logic        rise_rights, rise_reset, rise_start, stop_req;
  logic        reset_active;
  logic        remote_mode;
  logic        f1_ok, f2_ok;
  logic [$clog2(PURGE_CYC+1)-1:0] purge_cnt_ff;
  logic [prfc_pkg::VALVE_COUNT-1:0] valve_req_ff;
  logic        p1_run, p2_run;
  logic [7:0]  f1_ff, f2_ff;
  logic        run1_ff, run2_ff;

  function automatic logic [7:0] img_byte(input logic [8*prfc_pkg::IMG_BYTES-1:0] img, input int idx);
    img_byte = img[8*idx +: 8];
  endfunction : img_byte

  assign ctl_word = {img_byte(ctrl_img_i, prfc_pkg::OFS_SYS_CTRL + 1), img_byte(ctrl_img_i, prfc_pkg::OFS_SYS_CTRL)};
  assign b_valve  = img_byte(ctrl_img_i, prfc_pkg::OFS_VALVE_CTRL);
  assign b_p1     = img_byte(ctrl_img_i, prfc_pkg::OFS_PUMP1_CMD);
  assign b_p2     = img_byte(ctrl_img_i, prfc_pkg::OFS_PUMP2_CMD);
  assign b_f1     = img_byte(ctrl_img_i, prfc_pkg::OFS_PUMP1_FREQ);
  assign b_f2     = img_byte(ctrl_img_i, prfc_pkg::OFS_PUMP2_FREQ);
  assign b_mode   = img_byte(ctrl_img_i, prfc_pkg::OFS_MODE_REQ);

  // edges are judged against the last accepted telegram, not the last clock
  assign rise_rights = tel_valid_i && ctl_word[prfc_pkg::BIT_RIGHTS] && !prev_ctl_ff[prfc_pkg::BIT_RIGHTS];
  assign rise_reset  = tel_valid_i && ctl_word[prfc_pkg::BIT_RESET] && !prev_ctl_ff[prfc_pkg::BIT_RESET];
  assign rise_start  = tel_valid_i && ctl_word[prfc_pkg::BIT_START] && !prev_ctl_ff[prfc_pkg::BIT_START];
  assign stop_req    = tel_valid_i && !ctl_word[prfc_pkg::BIT_START] && prev_ctl_ff[prfc_pkg::BIT_START];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ctl_ff <= 16'h0000;
    end else if (tel_valid_i) begin
      prev_ctl_ff <= ctl_word;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      remote_rights_o <= 1'b0;
    end else if (rise_rights) begin
      remote_rights_o <= 1'b1;
    end
  end

  prfc_hold_timer #(
    .HOLD_CYC (HOLD_CYC)
  ) u_reset_hold (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .trig_i   (rise_reset && remote_rights_o),
    .active_o (reset_active)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b0;
    end else begin
      sys_reset_o <= reset_active;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sys_run_o <= 1'b0;
    end else if (reset_active) begin
      sys_run_o <= 1'b0;
    end else if (remote_rights_o && rise_start) begin
      sys_run_o <= 1'b1;
    end else if (remote_rights_o && stop_req) begin
      sys_run_o <= 1'b0;
    end
  end

  // unreleased codes other than remote command are ignored; master owns code choice
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o <= prfc_pkg::MODE_A;
    end else if (tel_valid_i && remote_rights_o && ctl_word[prfc_pkg::BIT_EN_MODE]) begin
      case (b_mode)
        prfc_pkg::MODE_A,
        prfc_pkg::MODE_B,
        prfc_pkg::MODE_C,
        prfc_pkg::MODE_REMOTE: mode_o <= b_mode;
        default: mode_o <= mode_o;
      endcase
    end
  end

  assign remote_mode = (mode_o == prfc_pkg::MODE_REMOTE);

  // plausibility: nonzero and within the stage maximum
  assign f1_ok = (b_f1 != 8'h00) && (b_f1 <= MAX_F1);
  assign f2_ok = (b_f2 != 8'h00) && (b_f2 <= MAX_F2);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      f1_ff <= 8'h00;
    end else if (tel_valid_i && remote_rights_o && ctl_word[prfc_pkg::BIT_EN_F1] && f1_ok) begin
      f1_ff <= b_f1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      f2_ff <= 8'h00;
    end else if (tel_valid_i && remote_rights_o && LINKED && ctl_word[prfc_pkg::BIT_EN_F1] && f1_ok) begin
      f2_ff <= b_f1;
    end else if (tel_valid_i && remote_rights_o && !LINKED && ctl_word[prfc_pkg::BIT_EN_F2] && f2_ok) begin
      f2_ff <= b_f2;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      freq_reject_o <= 1'b0;
    end else begin
      freq_reject_o <= tel_valid_i && remote_rights_o &&
                       ((ctl_word[prfc_pkg::BIT_EN_F1] && !f1_ok) ||
                        (!LINKED && ctl_word[prfc_pkg::BIT_EN_F2] && !f2_ok));
    end
  end

  assign p1_run = remote_mode ? b_p1[prfc_pkg::BIT_PUMP_RUN] : sys_run_o;
  assign p2_run = remote_mode ? (LINKED ? b_p1[prfc_pkg::BIT_PUMP_RUN]
                                        : b_p2[prfc_pkg::BIT_PUMP_RUN]) : sys_run_o;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      run1_ff <= 1'b0;
      run2_ff <= 1'b0;
    end else if (reset_active || !remote_rights_o) begin
      run1_ff <= 1'b0;
      run2_ff <= 1'b0;
    end else if (tel_valid_i || !remote_mode) begin
      run1_ff <= p1_run;
      run2_ff <= p2_run;
    end
  end

  // one driver per struct; each field keeps its own register
  assign pump1_o = {run1_ff, f1_ff};
  assign pump2_o = {run2_ff, f2_ff};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      valve_req_ff <= '0;
    end else if (tel_valid_i && remote_rights_o && ctl_word[prfc_pkg::BIT_EN_VALVE]) begin
      valve_req_ff <= b_valve[prfc_pkg::VALVE_COUNT-1:0];
    end
  end

  // purge window starts when a stop request switches the system off (not on internal reset); purge_done_i cuts it short
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      purge_cnt_ff <= '0;
    end else if (sys_run_o && remote_rights_o && stop_req) begin
      purge_cnt_ff <= ($bits(purge_cnt_ff))'(PURGE_CYC);
    end else if (purge_done_i) begin
      purge_cnt_ff <= '0;
    end else if (purge_cnt_ff != '0) begin
      purge_cnt_ff <= purge_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      purging_o <= 1'b0;
      valves_o  <= '0;
    end else begin
      purging_o <= (purge_cnt_ff != '0);
      valves_o  <= (purge_cnt_ff != '0) ? {prfc_pkg::VALVE_COUNT{1'b1}} : valve_req_ff;
    end
  end

  // status image; no bit carries bus-loss state, the bus module reports that
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stat_img_o <= '0;
    end else begin
      stat_img_o <= '0;
      stat_img_o[8*prfc_pkg::OFS_SYS_STATE +: 16] <=
        {1'b0, sys_warning_i, 3'b000, sys_run_o && upper_i.normal, 2'b00,
         sys_warning_i, !sys_run_o && (upper_i.decel || lower_i.decel), 1'b0,
         sys_run_o && (upper_i.accel || lower_i.accel), sys_error_i, 1'b0, sys_run_o, sys_ready_i};
      stat_img_o[8*prfc_pkg::OFS_VALVE_STATE +: 16] <= {13'h0000, valves_o};
      stat_img_o[8*prfc_pkg::OFS_UPPER_STATE +: 16] <=
        {1'b0, upper_i.warning, 2'b00, upper_i.turning, upper_i.normal, 4'h0,
         upper_i.decel, upper_i.accel, upper_i.error, 2'b00, upper_i.ready};
      stat_img_o[8*prfc_pkg::OFS_UPPER_FAULT +: 16] <= upper_i.fault_code;
      stat_img_o[8*prfc_pkg::OFS_UPPER_TEMP +: 8]   <= upper_i.temp;
      stat_img_o[8*prfc_pkg::OFS_UPPER_CONV_T +: 8] <= upper_i.conv_temp;
      stat_img_o[8*prfc_pkg::OFS_UPPER_F_TGT +: 8]  <= pump1_o.freq;
      stat_img_o[8*prfc_pkg::OFS_UPPER_F_ACT +: 8]  <= upper_i.freq_act;
      stat_img_o[8*prfc_pkg::OFS_UPPER_I_ACT +: 8]  <= upper_i.curr_act;
      stat_img_o[8*prfc_pkg::OFS_ENCL_TEMP +: 8]    <= encl_temp_i;
      stat_img_o[8*prfc_pkg::OFS_LOWER_STATE +: 16] <=
        {1'b0, lower_i.warning, 2'b00, lower_i.turning, lower_i.normal, 4'h0,
         lower_i.decel, lower_i.accel, lower_i.error, 2'b00, lower_i.ready};
      stat_img_o[8*prfc_pkg::OFS_LOWER_FAULT +: 16] <= lower_i.fault_code;
      stat_img_o[8*prfc_pkg::OFS_LOWER_TEMP +: 8]   <= lower_i.temp;
      stat_img_o[8*prfc_pkg::OFS_LOWER_CONV_T +: 8] <= lower_i.conv_temp;
      stat_img_o[8*prfc_pkg::OFS_LOWER_F_TGT +: 8]  <= pump2_o.freq;
      stat_img_o[8*prfc_pkg::OFS_LOWER_F_ACT +: 8]  <= lower_i.freq_act;
      stat_img_o[8*prfc_pkg::OFS_LOWER_I_ACT +: 8]  <= lower_i.curr_act;
      stat_img_o[8*prfc_pkg::OFS_MODE_STATE +: 8]   <= mode_o;
    end
  end
endmodule : prfc_command

// ===== prfc_command_checker.sv
`timescale 1ns/1ns
module prfc_command_checker #(
  parameter int         HOLD_CYC = 20,
  parameter logic [7:0] MAX_F1   = 8'h64,
  parameter logic [7:0] MAX_F2   = 8'h78,
  parameter logic       LINKED   = 1'b0
) (
  input wire logic                        clock_i,
  input wire logic                        rst_i,
  input wire logic                        tel_valid_i,
  input wire logic [8*prfc_pkg::IMG_BYTES-1:0] ctrl_img_i,
  input wire logic                        remote_rights_o,
  input wire logic                        sys_reset_o,
  input wire logic                        sys_run_o,
  input wire logic [7:0]                  mode_o,
  input wire prfc_pkg::prfc_pump_cmd_t    pump1_o,
  input wire prfc_pkg::prfc_pump_cmd_t    pump2_o,
  input wire logic [prfc_pkg::VALVE_COUNT-1:0] valves_o,
  input wire logic                        purging_o,
  input wire logic                        freq_reject_o
);
  int cnt_ff;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= sys_reset_o ? cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_took(int b);
    $past(tel_valid_i) && $past(ctrl_img_i[b]);
  endsequence
  sequence s_reset_held;
    sys_reset_o ##1 sys_reset_o;
  endsequence
  AST_NO_RIGHTS: assert property (!remote_rights_o |-> !sys_run_o && !pump1_o.run && !pump2_o.run)
    else $error("run without rights");
  AST_RIGHTS_KEEP: assert property (remote_rights_o |=> remote_rights_o)
    else $error("rights dropped");
  AST_RIGHTS_EDGE: assert property ($rose(remote_rights_o) |-> s_took(10))
    else $error("rights without request");
  AST_RUN_EDGE: assert property ($rose(sys_run_o) |-> s_took(0))
    else $error("run without start");
  AST_MODE_CAUSE: assert property ($changed(mode_o) && mode_o != 8'h00 |-> s_took(8) ##0 mode_o == $past(ctrl_img_i[184+:8]))
    else $error("mode changed without enable");
  AST_MODE_LEGAL: assert property (mode_o inside {8'h00, 8'h01, 8'h02, 8'h07})
    else $error("illegal mode");
  AST_F_RANGE: assert property (pump1_o.freq <= MAX_F1 && pump2_o.freq <= MAX_F2)
    else $error("setpoint above max");
  AST_F1_CAUSE: assert property ($changed(pump1_o.freq) && pump1_o.freq != 8'h00 |-> s_took(5) ##0 pump1_o.freq == $past(ctrl_img_i[80+:8]))
    else $error("pump1 setpoint without enable");
  AST_F2_CAUSE: assert property ($changed(pump2_o.freq) && pump2_o.freq != 8'h00 |->
    s_took(LINKED ? 5 : 6) ##0 pump2_o.freq == $past(ctrl_img_i[(LINKED ? 80 : 160)+:8]))
    else $error("pump2 setpoint without enable");
  AST_REJECT: assert property (freq_reject_o |-> $past(tel_valid_i) && ($past(ctrl_img_i[5]) || $past(ctrl_img_i[6])))
    else $error("reject without setpoint");
  AST_RESET_LEN: assert property ($fell(sys_reset_o) |-> cnt_ff == HOLD_CYC)
    else $error("reset stretch length wrong");
  AST_RESET_STOPS: assert property (s_reset_held |-> !sys_run_o && !pump1_o.run && !pump2_o.run)
    else $error("running during reset");
  AST_PURGE: assert property (purging_o |-> valves_o == 3'b111)
    else $error("purge valves not open");
endmodule : prfc_command_checker
bind prfc_command prfc_command_checker #(.HOLD_CYC(HOLD_CYC), .MAX_F1(MAX_F1), .MAX_F2(MAX_F2), .LINKED(LINKED))
  u_prfc_command_checker (
  .clock_i(clock_i), .rst_i(rst_i), .tel_valid_i(tel_valid_i), .ctrl_img_i(ctrl_img_i),
  .remote_rights_o(remote_rights_o), .sys_reset_o(sys_reset_o), .sys_run_o(sys_run_o), .mode_o(mode_o),
  .pump1_o(pump1_o), .pump2_o(pump2_o), .valves_o(valves_o), .purging_o(purging_o), .freq_reject_o(freq_reject_o));

// ===== prfc_hold_timer.sv
`timescale 1ns/1ns
module prfc_hold_timer #(
  parameter int HOLD_CYC = prfc_pkg::RESET_HOLD_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic trig_i,
  output logic      active_o
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] count_ff;

  // a retrigger restarts the full hold time
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (trig_i) begin
      count_ff <= CW'(HOLD_CYC);
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= trig_i || (count_ff > CW'(1));
    end
  end
endmodule : prfc_hold_timer

// ===== prfc_master_model.sv
`timescale 1ns/1ns
module prfc_master_model (
  input  wire logic                        clock_i,
  output logic                             tel_valid_o,
  output logic [8*prfc_pkg::IMG_BYTES-1:0] ctrl_img_o
);
  initial begin
    tel_valid_o = 1'b0;
    ctrl_img_o  = '0;
  end
  // edges exist only as a 0 telegram followed by a 1 telegram
  task automatic send(input logic [8*prfc_pkg::IMG_BYTES-1:0] img);
    @(negedge clock_i);
    ctrl_img_o  = img;
    tel_valid_o = 1'b1;
    @(negedge clock_i);
    tel_valid_o = 1'b0;
    // stale image must not look valid, so show its inverse
    ctrl_img_o  = ~img;
  endtask : send
endmodule : prfc_master_model

// ===== prfc_pkg.sv
package prfc_pkg;

  localparam int IMG_BYTES = 32;

  localparam int OFS_SYS_CTRL      = 'h0;
  localparam int OFS_VALVE_CTRL    = 'h2;
  localparam int OFS_PUMP1_CMD     = 'h4;
  localparam int OFS_PUMP1_FREQ    = 'hA;
  localparam int OFS_PUMP2_CMD     = 'hE;
  localparam int OFS_PUMP2_FREQ    = 'h14;
  localparam int OFS_MODE_REQ      = 'h17;

  localparam int OFS_SYS_STATE     = 'h0;
  localparam int OFS_VALVE_STATE   = 'h2;
  localparam int OFS_UPPER_STATE   = 'h4;
  localparam int OFS_UPPER_FAULT   = 'h6;
  localparam int OFS_UPPER_TEMP    = 'h8;
  localparam int OFS_UPPER_CONV_T  = 'h9;
  localparam int OFS_UPPER_F_TGT   = 'hA;
  localparam int OFS_UPPER_F_ACT   = 'hB;
  localparam int OFS_UPPER_I_ACT   = 'hC;
  localparam int OFS_ENCL_TEMP     = 'hD;
  localparam int OFS_LOWER_STATE   = 'hE;
  localparam int OFS_LOWER_FAULT   = 'h10;
  localparam int OFS_LOWER_TEMP    = 'h12;
  localparam int OFS_LOWER_CONV_T  = 'h13;
  localparam int OFS_LOWER_F_TGT   = 'h14;
  localparam int OFS_LOWER_F_ACT   = 'h15;
  localparam int OFS_LOWER_I_ACT   = 'h16;
  localparam int OFS_MODE_STATE    = 'h17;

  localparam int BIT_START         = 0;
  localparam int BIT_EN_F1         = 5;
  localparam int BIT_EN_F2         = 6;
  localparam int BIT_RESET         = 7;
  localparam int BIT_EN_MODE       = 8;
  localparam int BIT_RIGHTS        = 10;
  localparam int BIT_EN_VALVE      = 11;
  localparam int BIT_PUMP_RUN      = 0;
  localparam int VALVE_COUNT       = 3;

  localparam logic [7:0] MODE_A      = 8'h00;
  localparam logic [7:0] MODE_B      = 8'h01;
  localparam logic [7:0] MODE_C      = 8'h02;
  localparam logic [7:0] MODE_REMOTE = 8'h07;

  localparam logic [7:0] MAX_F_ROOTS = 8'h64;
  localparam logic [7:0] MAX_F_SCREW = 8'h78;

  localparam int CLK_HZ            = 10_000_000;
  localparam int RESET_HOLD_MS     = 3000;
  localparam int RESET_HOLD_CYC    = (CLK_HZ / 1000) * RESET_HOLD_MS;

  typedef struct packed {
    logic       run;
    logic [7:0] freq;
  } prfc_pump_cmd_t;

  typedef struct packed {
    logic       ready;
    logic       error;
    logic       accel;
    logic       decel;
    logic       normal;
    logic       turning;
    logic       warning;
    logic [15:0] fault_code;
    logic [7:0] temp;
    logic [7:0] conv_temp;
    logic [7:0] freq_act;
    logic [7:0] curr_act;
  } prfc_pump_state_t;

endpackage : prfc_pkg

// ===== tb_prfc_command.sv
`timescale 1ns/1ns
module tb_prfc_command;
  localparam int          HOLD   = 20;
  localparam int          PURGE  = 30;
  localparam logic [47:0] M_ALL  = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] M_RUNS = 48'hFFEF_F7FF_FFFF;
  logic                       clock_i, rst_i, tel_valid_i, purge_done_i, sys_ready_i, sys_error_i, sys_warning_i;
  logic [255:0]               ctrl_img_i, stat_img_o, img;
  prfc_pkg::prfc_pump_state_t upper_i, lower_i;
  prfc_pkg::prfc_pump_cmd_t   pump1_o, pump2_o, lk_p2;
  logic [7:0]                 encl_temp_i, mode_o, e_mode, v, mx;
  logic                       remote_rights_o, sys_reset_o, sys_run_o, purging_o, freq_reject_o;
  logic                       e_rights, e_run, e_rst, en, e_purg;
  logic [2:0]                 valves_o, e_valves;
  logic [8:0]                 e_p1, e_p2;
  logic [47:0]                msk;
  logic [47:0]                exp_q[$], msk_q[$];
  logic [17:0]                x_q[$];
  int                         errors, n_checks, n_rej, e_rej;
  event                       smp;
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  prfc_command #(.HOLD_CYC(HOLD), .PURGE_CYC(PURGE)) u_prfc_command (
    .clock_i(clock_i), .rst_i(rst_i), .tel_valid_i(tel_valid_i), .ctrl_img_i(ctrl_img_i),
    .purge_done_i(purge_done_i), .upper_i(upper_i), .lower_i(lower_i), .sys_ready_i(sys_ready_i),
    .sys_error_i(sys_error_i), .sys_warning_i(sys_warning_i), .encl_temp_i(encl_temp_i),
    .stat_img_o(stat_img_o), .remote_rights_o(remote_rights_o), .sys_reset_o(sys_reset_o),
    .sys_run_o(sys_run_o), .mode_o(mode_o), .pump1_o(pump1_o), .pump2_o(pump2_o), .valves_o(valves_o),
    .purging_o(purging_o), .freq_reject_o(freq_reject_o));
  prfc_master_model u_prfc_master_model (.clock_i(clock_i), .tel_valid_o(tel_valid_i), .ctrl_img_o(ctrl_img_i));
  // second copy built as the linked variant; only its pump 2 command is watched
  prfc_command #(.HOLD_CYC(HOLD), .PURGE_CYC(PURGE), .LINKED(1'b1)) u_prfc_command_linked (
    .clock_i(clock_i), .rst_i(rst_i), .tel_valid_i(tel_valid_i), .ctrl_img_i(ctrl_img_i),
    .purge_done_i(purge_done_i), .upper_i(upper_i), .lower_i(lower_i), .sys_ready_i(sys_ready_i),
    .sys_error_i(sys_error_i), .sys_warning_i(sys_warning_i), .encl_temp_i(encl_temp_i),
    .stat_img_o(), .remote_rights_o(), .sys_reset_o(), .sys_run_o(), .mode_o(), .pump1_o(),
    .pump2_o(lk_p2), .valves_o(), .purging_o(), .freq_reject_o());
  always @(posedge clock_i) begin
    if (freq_reject_o === 1'b1) begin
      n_rej++;
    end
  end
  function automatic logic [47:0] act_vec();
    return {sys_reset_o, remote_rights_o, sys_run_o, mode_o, pump1_o, pump2_o, valves_o,
            stat_img_o[184+:8], stat_img_o[104+:8]};
  endfunction : act_vec
  always @(smp) begin
    logic [47:0] e, m;
    logic [17:0] x;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    x = x_q.pop_front();
    n_checks++;
    if ((act_vec() & m) !== (e & m)) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, act_vec() & m, e & m);
    end
    n_checks++;
    if ({purging_o, 8'(n_rej), lk_p2 & m[36:28]} !== {x[17:9], x[8:0] & m[36:28]}) begin
      errors++;
      $display("unexpected at %0t: purge/reject/linked got %h want %h", $time, {purging_o, 8'(n_rej), lk_p2}, x);
    end
  end
  task automatic tx();
    u_prfc_master_model.send(img);
    repeat (5) @(negedge clock_i);
    exp_q.push_back({e_rst, e_rights, e_run, e_mode, e_p1, e_p2, e_valves, e_mode, encl_temp_i});
    msk_q.push_back(msk);
    x_q.push_back({e_purg, 8'(e_rej), e_p1});
    -> smp;
    // compare runs before the caller moves on, so a reset or the verdict cannot race it
    @(negedge clock_i);
  endtask : tx
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(16508));
    rst_i = 1'b1;
    purge_done_i = 1'b0;
    e_purg = 1'b0;
    {sys_ready_i, sys_error_i, sys_warning_i, encl_temp_i} = 11'($urandom);
    upper_i = 55'({$urandom, $urandom});
    lower_i = 55'({$urandom, $urandom});
    img = '0;
    msk = M_RUNS;
    {e_rst, e_rights, e_run, e_mode, e_p1, e_p2, e_valves} = '0;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    img[0] = 1'b1;
    tx();
    img[0] = 1'b0;
    img[10] = 1'b1;
    e_rights = 1'b1;
    tx();
    img[184+:8] = 8'h02;
    tx();
    img[8] = 1'b1;
    for (int m = 0; m < 8; m++) begin
      img[184+:8] = 8'(m);
      if (m < 3 || m == 7) e_mode = 8'(m);
      tx();
    end
    msk = M_ALL;
    for (int i = 0; i < 10; i++) begin
      mx = (i < 5) ? prfc_pkg::MAX_F_ROOTS : prfc_pkg::MAX_F_SCREW;
      en = (i % 5 != 4);
      case (i % 5)
        0: v = 8'h00;
        1: v = mx + 8'h01;
        2: v = mx;
        3: v = 8'($urandom_range(1, int'(mx)));
        default: v = 8'h32;
      endcase
      img[80+:8] = v;
      img[160+:8] = v;
      img[5] = (i < 5) && en;
      img[6] = (i >= 5) && en;
      if (en && v != 8'h00 && v <= mx && i < 5) e_p1[7:0] = v;
      if (en && v != 8'h00 && v <= mx && i >= 5) e_p2[7:0] = v;
      if (en && (v == 8'h00 || v > mx)) e_rej++;
      tx();
    end
    img[5] = 1'b0;
    img[6] = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      img[32] = k[0];
      img[112] = k[1];
      e_p1[8] = k[0];
      e_p2[8] = k[1];
      tx();
    end
    img[16+:3] = 3'b101;
    tx();
    img[11] = 1'b1;
    e_valves = 3'b101;
    tx();
    img[16+:3] = 3'($urandom);
    e_valves = img[16+:3];
    tx();
    msk = M_RUNS;
    img[0] = 1'b1;
    e_run = 1'b1;
    tx();
    img[0] = 1'b0;
    e_run = 1'b0;
    e_valves = 3'b111;
    e_purg = 1'b1;
    tx();
    repeat (PURGE) @(negedge clock_i);
    e_purg = 1'b0;
    msk = 48'hA000_0000_0000;
    img[7] = 1'b1;
    e_rst = 1'b1;
    tx();
    img[7] = 1'b0;
    repeat (HOLD) @(negedge clock_i);
    e_rst = 1'b0;
    tx();
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    img = '0;
    msk = M_ALL;
    {e_rst, e_rights, e_run, e_mode, e_p1, e_p2, e_valves} = '0;
    tx();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    errors++;
    summarize();
  end
endmodule : tb_prfc_command
